/* File: hdl/imfu_defs.svh */
// register offsets, field positions, reset values and vector addresses
// assumes inclusion by bare name from the design files
`ifndef IMFU_DEFS_SVH
`define IMFU_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define IMFU_OFS_TIMER_FLAGS 6'h38
`define IMFU_OFS_TIMER_MASK 6'h39
`define IMFU_OFS_EXT_FLAGS 6'h3a
`define IMFU_OFS_EXT_MASK 6'h3b
`define IMFU_OFS_CORE_CTRL 6'h35
`define IMFU_OFS_CORE_STATUS 6'h3f

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define IMFU_BIT_PIN1 7
`define IMFU_BIT_PIN0 6
`define IMFU_BIT_T1_OVF 7
`define IMFU_BIT_T1_CMPA 6
`define IMFU_BIT_T1_CMPB 5
`define IMFU_BIT_T1_CAP 3
`define IMFU_BIT_T0_OVF 1
`define IMFU_BIT_GIE 7
`define IMFU_EXT_USED 8'hc0
`define IMFU_TIMER_USED 8'hea
`define IMFU_STATUS_USED 8'h80

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define IMFU_RST_REG 8'h00

// ----------------------------------------------------------------
// sense control codes
// ----------------------------------------------------------------
`define IMFU_SENSE_LOW 2'h0
`define IMFU_SENSE_RSVD 2'h1
`define IMFU_SENSE_FALL 2'h2
`define IMFU_SENSE_RISE 2'h3

// ----------------------------------------------------------------
// vector addresses
// ----------------------------------------------------------------
`define IMFU_VEC_NONE 3'h0
`define IMFU_VEC_PIN0 3'h1
`define IMFU_VEC_PIN1 3'h2
`define IMFU_VEC_T1_CAP 3'h3
`define IMFU_VEC_T1_CMPA 3'h4
`define IMFU_VEC_T1_CMPB 3'h5
`define IMFU_VEC_T1_OVF 3'h6
`define IMFU_VEC_T0_OVF 3'h7

`endif

/* File: hdl/imfu_pkg.sv */
// types shared by the interrupt mask and flag unit
// assumes imfu_defs.svh holds all numeric constants
package imfu_pkg;

  typedef struct packed {
    logic [7:0] ext_irq_mask;
    logic [7:0] ext_irq_flags;
    logic [7:0] timer_irq_mask;
    logic [7:0] timer_irq_flags;
    logic [3:0] sense;
    logic gie;
    logic [1:0] pin_prev;
    logic [7:0] rdata;
    logic irq_req;
    logic [2:0] irq_vector;
  } imfu_state_t;

endpackage

/* File: hdl/imfu_top.sv */
// interrupt mask, flag and priority logic of a small microcontroller
// assumes inputs synchronous to clk, timer events as one-cycle pulses,
// core takes a vector with vector_ack one cycle after irq_req is seen
//
// What this block does
// - pin 0 request enabled only with its mask bit 6 and global enable.
// - each pin's sense field picks rising, falling or low level detect.
// - pin activity requests even when the pin is driven as output.
// - pin 0 request vectors to address 001.
// - unused bits of mask and flag registers read as zero.
// - pin 1 flag bit 7 sets on event; vectors to 002 when enabled.
// - pin 0 flag bit 6 sets on event; vectors when enabled.
// - flags clear on vectoring or write one; write zero leaves them.
// - timer 1 overflow enabled by mask bit 7, vector 006.
// - compare A enabled by mask bit 6, vector 004.
// - compare B enabled by mask bit 5, vector 005.
// - capture enabled by mask bit 3, vector 003.
// - timer 0 overflow enabled by mask bit 1, vector 007.
// - timer 1 overflow flag sets on overflow or pwm turn at zero.
// - compare A flag bit 6 sets on count match with value A.
// - compare B flag bit 5 sets on count match with value B.
// - capture flag bit 3 sets when count copied to capture value.
// - timer 0 overflow flag bit 1 sets on timer 0 overflow.
// - enabled low-level pin keeps requesting while the pin stays low.
// - sense code 00 low, 01 reserved, 10 falling, 11 rising.
// - pin sampled before edge detect; pulses over one clock caught.
// - flags stay set while disabled, served once enabled.
`timescale 1ns/1ps
`include "imfu_defs.svh"

module imfu_top (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // external request pins, read back from the pad
  input wire logic [1:0] ext_pin,
  // timer events
  input wire logic t1_overflow,
  input wire logic t1_pwm_turn_zero,
  input wire logic t1_cmp_a_match,
  input wire logic t1_cmp_b_match,
  input wire logic t1_capture_event,
  input wire logic t0_overflow,
  // core side
  input wire logic vector_ack,
  output logic irq_req,
  output logic [2:0] irq_vector
);

  imfu_pkg::imfu_state_t st;
  imfu_pkg::imfu_state_t next_st;

  // ----------------------------------------------------------------
  // pin detection
  // ----------------------------------------------------------------
  logic [1:0] pin_event;
  logic [1:0] pin_level;

  // pad value used whatever the pin direction
  for (genvar i = 0; i < 2; i++) begin : g_pin
    logic [1:0] code;
    assign code = st.sense[2*i +: 2];
    always_comb begin
      pin_event[i] = 1'b0;
      pin_level[i] = 1'b0;
      case (code)
        `IMFU_SENSE_LOW: pin_level[i] = ~ext_pin[i];
        `IMFU_SENSE_FALL: pin_event[i] = st.pin_prev[i] & ~ext_pin[i];
        `IMFU_SENSE_RISE: pin_event[i] = ~st.pin_prev[i] & ext_pin[i];
        default: pin_event[i] = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pending sources and priority
  // ----------------------------------------------------------------
  logic [7:0] ext_flags_in;
  logic [7:0] pend;
  logic [2:0] win;
  logic [7:0] t_set;
  logic [7:0] e_set;

  always_comb begin
    t_set = 8'h00;
    t_set[`IMFU_BIT_T1_OVF] = t1_overflow | t1_pwm_turn_zero;
    t_set[`IMFU_BIT_T1_CMPA] = t1_cmp_a_match;
    t_set[`IMFU_BIT_T1_CMPB] = t1_cmp_b_match;
    t_set[`IMFU_BIT_T1_CAP] = t1_capture_event;
    t_set[`IMFU_BIT_T0_OVF] = t0_overflow;
    e_set = 8'h00;
    e_set[`IMFU_BIT_PIN1] = pin_event[1];
    e_set[`IMFU_BIT_PIN0] = pin_event[0];
  end

  // level mode has no flag; request follows the pin
  assign ext_flags_in = st.ext_irq_flags
    | {pin_level[1], pin_level[0], 6'h00};

  // pend index = vector address; flags stay until served
  always_comb begin
    pend = 8'h00;
    pend[`IMFU_VEC_PIN0] = ext_flags_in[`IMFU_BIT_PIN0]
      & st.ext_irq_mask[`IMFU_BIT_PIN0];
    pend[`IMFU_VEC_PIN1] = ext_flags_in[`IMFU_BIT_PIN1]
      & st.ext_irq_mask[`IMFU_BIT_PIN1];
    pend[`IMFU_VEC_T1_CAP] = st.timer_irq_flags[`IMFU_BIT_T1_CAP]
      & st.timer_irq_mask[`IMFU_BIT_T1_CAP];
    pend[`IMFU_VEC_T1_CMPA] = st.timer_irq_flags[`IMFU_BIT_T1_CMPA]
      & st.timer_irq_mask[`IMFU_BIT_T1_CMPA];
    pend[`IMFU_VEC_T1_CMPB] = st.timer_irq_flags[`IMFU_BIT_T1_CMPB]
      & st.timer_irq_mask[`IMFU_BIT_T1_CMPB];
    pend[`IMFU_VEC_T1_OVF] = st.timer_irq_flags[`IMFU_BIT_T1_OVF]
      & st.timer_irq_mask[`IMFU_BIT_T1_OVF];
    pend[`IMFU_VEC_T0_OVF] = st.timer_irq_flags[`IMFU_BIT_T0_OVF]
      & st.timer_irq_mask[`IMFU_BIT_T0_OVF];
    if (!st.gie) begin
      pend = 8'h00;
    end
  end

  // lowest address first
  always_comb begin
    win = `IMFU_VEC_NONE;
    for (int k = 7; k >= 1; k--) begin
      if (pend[k]) begin
        win = 3'(k);
      end
    end
  end

  // ----------------------------------------------------------------
  // state update
  // ----------------------------------------------------------------
  logic [7:0] e_clr;
  logic [7:0] t_clr;

  always_comb begin
    e_clr = 8'h00;
    t_clr = 8'h00;
    // write one clears, zero leaves
    if (wr && addr == `IMFU_OFS_EXT_FLAGS) begin
      e_clr = wdata;
    end
    if (wr && addr == `IMFU_OFS_TIMER_FLAGS) begin
      t_clr = wdata;
    end
    // vector taken clears its own flag
    if (vector_ack) begin
      case (st.irq_vector)
        `IMFU_VEC_PIN0: e_clr[`IMFU_BIT_PIN0] = 1'b1;
        `IMFU_VEC_PIN1: e_clr[`IMFU_BIT_PIN1] = 1'b1;
        `IMFU_VEC_T1_CAP: t_clr[`IMFU_BIT_T1_CAP] = 1'b1;
        `IMFU_VEC_T1_CMPA: t_clr[`IMFU_BIT_T1_CMPA] = 1'b1;
        `IMFU_VEC_T1_CMPB: t_clr[`IMFU_BIT_T1_CMPB] = 1'b1;
        `IMFU_VEC_T1_OVF: t_clr[`IMFU_BIT_T1_OVF] = 1'b1;
        `IMFU_VEC_T0_OVF: t_clr[`IMFU_BIT_T0_OVF] = 1'b1;
        default: t_clr = t_clr;
      endcase
    end
  end

  always_comb begin
    next_st = st;
    next_st.pin_prev = ext_pin;
    // set beats clear in the same cycle
    next_st.ext_irq_flags = ((st.ext_irq_flags & ~e_clr) | e_set)
      & `IMFU_EXT_USED;
    next_st.timer_irq_flags = ((st.timer_irq_flags & ~t_clr) | t_set)
      & `IMFU_TIMER_USED;
    if (wr) begin
      case (addr)
        `IMFU_OFS_EXT_MASK: next_st.ext_irq_mask = wdata & `IMFU_EXT_USED;
        `IMFU_OFS_TIMER_MASK:
          next_st.timer_irq_mask = wdata & `IMFU_TIMER_USED;
        `IMFU_OFS_CORE_CTRL: next_st.sense = wdata[3:0];
        `IMFU_OFS_CORE_STATUS: next_st.gie = wdata[`IMFU_BIT_GIE];
        default: next_st.gie = st.gie;
      endcase
    end
    // vector_ack clears global enable on vector entry
    if (vector_ack) begin
      next_st.gie = 1'b0;
    end
    next_st.rdata = 8'h00;
    if (rd) begin
      case (addr) // unused bits held at zero
        `IMFU_OFS_EXT_MASK: next_st.rdata = st.ext_irq_mask;
        `IMFU_OFS_EXT_FLAGS: next_st.rdata = st.ext_irq_flags;
        `IMFU_OFS_TIMER_MASK: next_st.rdata = st.timer_irq_mask;
        `IMFU_OFS_TIMER_FLAGS: next_st.rdata = st.timer_irq_flags;
        `IMFU_OFS_CORE_CTRL: next_st.rdata = {4'h0, st.sense};
        `IMFU_OFS_CORE_STATUS: next_st.rdata = {st.gie, 7'h00};
        default: next_st.rdata = 8'h00;
      endcase
    end
    next_st.irq_req = (win != `IMFU_VEC_NONE) && !vector_ack;
    next_st.irq_vector = vector_ack ? `IMFU_VEC_NONE : win;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
      st.pin_prev <= 2'h3;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign irq_req = st.irq_req;
  assign irq_vector = st.irq_vector;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_pin0_gate: assert property (@(posedge clk) disable iff (srst)
    irq_req && irq_vector == `IMFU_VEC_PIN0 |->
      $past(st.gie) && $past(st.ext_irq_mask[`IMFU_BIT_PIN0]))
    else $error("pin 0 served while disabled");

  a_fall_detect: assert property (@(posedge clk) disable iff (srst)
    st.sense[1:0] == `IMFU_SENSE_FALL && st.pin_prev[0] && !ext_pin[0]
      && !(wr && addr == `IMFU_OFS_CORE_CTRL) |=> st.ext_irq_flags[6])
    else $error("falling edge on pin 0 missed");

  a_rise_pin1: assert property (@(posedge clk) disable iff (srst)
    st.sense[3:2] == `IMFU_SENSE_RISE && !st.pin_prev[1] && ext_pin[1]
      |=> st.ext_irq_flags[7])
    else $error("rising edge on pin 1 missed");

  a_reserved_zero: assert property (@(posedge clk) disable iff (srst)
    (st.ext_irq_flags & ~`IMFU_EXT_USED) == 8'h00
    && (st.timer_irq_mask & ~`IMFU_TIMER_USED) == 8'h00)
    else $error("reserved bit set");

  a_w1c_clear: assert property (@(posedge clk) disable iff (srst)
    wr && addr == `IMFU_OFS_TIMER_FLAGS && wdata[1] && !t0_overflow
      |=> !st.timer_irq_flags[1])
    else $error("write one did not clear");

  a_w0_keep: assert property (@(posedge clk) disable iff (srst)
    wr && addr == `IMFU_OFS_TIMER_FLAGS && !wdata[7] && st.timer_irq_flags[7]
      && !(vector_ack && irq_vector == `IMFU_VEC_T1_OVF)
      |=> st.timer_irq_flags[7])
    else $error("write zero changed a flag");

  a_t1_ovf_set: assert property (@(posedge clk) disable iff (srst)
    t1_pwm_turn_zero |=> st.timer_irq_flags[7])
    else $error("pwm turn did not set overflow flag");

  a_cmp_vector: assert property (@(posedge clk) disable iff (srst)
    st.gie && st.timer_irq_flags[6] && st.timer_irq_mask[6]
      && pend[3:1] == 3'h0 && !vector_ack
      |=> irq_req && irq_vector == `IMFU_VEC_T1_CMPA)
    else $error("compare A not vectored to 004");

  a_level_hold: assert property (@(posedge clk) disable iff (srst)
    st.gie && st.ext_irq_mask[6] && st.sense[1:0] == `IMFU_SENSE_LOW
      && !ext_pin[0] && !vector_ack |=> irq_req)
    else $error("low level not requesting");

  // ----------------------------------------------------------------
  // checks: flag setting
  // ----------------------------------------------------------------
  a_t1_wrap_set: assert property (@(posedge clk) disable iff (srst)
    t1_overflow |=> st.timer_irq_flags[7])
    else $error("timer 1 overflow did not set its flag");

  a_cmpa_set: assert property (@(posedge clk) disable iff (srst)
    t1_cmp_a_match |=> st.timer_irq_flags[6])
    else $error("compare A match did not set its flag");

  a_cmpb_set: assert property (@(posedge clk) disable iff (srst)
    t1_cmp_b_match |=> st.timer_irq_flags[5])
    else $error("compare B match did not set its flag");

  a_cap_set: assert property (@(posedge clk) disable iff (srst)
    t1_capture_event |=> st.timer_irq_flags[3])
    else $error("capture event did not set its flag");

  a_t0ovf_set: assert property (@(posedge clk) disable iff (srst)
    t0_overflow |=> st.timer_irq_flags[1])
    else $error("timer 0 overflow did not set its flag");

  a_rise_pin0: assert property (@(posedge clk) disable iff (srst)
    st.sense[1:0] == `IMFU_SENSE_RISE && !st.pin_prev[0] && ext_pin[0]
      |=> st.ext_irq_flags[6])
    else $error("rising edge on pin 0 missed");

  a_fall_pin1: assert property (@(posedge clk) disable iff (srst)
    st.sense[3:2] == `IMFU_SENSE_FALL && st.pin_prev[1] && !ext_pin[1]
      |=> st.ext_irq_flags[7])
    else $error("falling edge on pin 1 missed");

  a_rsvd_sense: assert property (@(posedge clk) disable iff (srst)
    st.sense[1:0] == `IMFU_SENSE_RSVD && !st.ext_irq_flags[6]
      |=> !st.ext_irq_flags[6])
    else $error("reserved sense code raised pin 0 flag");

  a_lvl_no_flag: assert property (@(posedge clk) disable iff (srst)
    st.sense[1:0] == `IMFU_SENSE_LOW && !st.ext_irq_flags[6]
      |=> !st.ext_irq_flags[6])
    else $error("low level mode raised pin 0 flag");

  a_pin_history: assert property (@(posedge clk) disable iff (srst)
    1'b1 |=> st.pin_prev == $past(ext_pin))
    else $error("pin history not taken from last sample");

  a_flag_kept: assert property (@(posedge clk) disable iff (srst)
    !st.gie && st.timer_irq_flags[3] && !vector_ack
      && !(wr && addr == `IMFU_OFS_TIMER_FLAGS) |=> st.timer_irq_flags[3])
    else $error("flag lost while interrupts were off");

  a_mask_unused: assert property (@(posedge clk) disable iff (srst)
    (st.ext_irq_mask & ~`IMFU_EXT_USED) == 8'h00
    && (st.timer_irq_flags & ~`IMFU_TIMER_USED) == 8'h00)
    else $error("unused mask or flag bit set");

  // ----------------------------------------------------------------
  // checks: vectoring
  // ----------------------------------------------------------------
  a_pin0_vec: assert property (@(posedge clk) disable iff (srst)
    st.gie && st.ext_irq_mask[6] && st.ext_irq_flags[6] && !vector_ack
      |=> irq_req && irq_vector == `IMFU_VEC_PIN0)
    else $error("pin 0 not vectored to 001");

  a_pin1_vec: assert property (@(posedge clk) disable iff (srst)
    st.gie && st.ext_irq_mask[7] && st.ext_irq_flags[7] && !pend[1]
      && !vector_ack |=> irq_req && irq_vector == `IMFU_VEC_PIN1)
    else $error("pin 1 not vectored to 002");

  a_pin1_gate: assert property (@(posedge clk) disable iff (srst)
    irq_req && irq_vector == `IMFU_VEC_PIN1 |->
      $past(st.gie) && $past(st.ext_irq_mask[`IMFU_BIT_PIN1]))
    else $error("pin 1 served while disabled");

  a_cap_vec: assert property (@(posedge clk) disable iff (srst)
    st.gie && st.timer_irq_mask[3] && st.timer_irq_flags[3]
      && pend[2:1] == 2'h0 && !vector_ack
      |=> irq_req && irq_vector == `IMFU_VEC_T1_CAP)
    else $error("capture not vectored to 003");

  a_cmpb_vec: assert property (@(posedge clk) disable iff (srst)
    st.gie && st.timer_irq_mask[5] && st.timer_irq_flags[5]
      && pend[4:1] == 4'h0 && !vector_ack
      |=> irq_req && irq_vector == `IMFU_VEC_T1_CMPB)
    else $error("compare B not vectored to 005");

  a_t1ovf_vec: assert property (@(posedge clk) disable iff (srst)
    st.gie && st.timer_irq_mask[7] && st.timer_irq_flags[7]
      && pend[5:1] == 5'h00 && !vector_ack
      |=> irq_req && irq_vector == `IMFU_VEC_T1_OVF)
    else $error("timer 1 overflow not vectored to 006");

  a_t0ovf_vec: assert property (@(posedge clk) disable iff (srst)
    st.gie && st.timer_irq_mask[1] && st.timer_irq_flags[1]
      && pend[6:1] == 6'h00 && !vector_ack
      |=> irq_req && irq_vector == `IMFU_VEC_T0_OVF)
    else $error("timer 0 overflow not vectored to 007");

  a_gie_quiet: assert property (@(posedge clk) disable iff (srst)
    !st.gie |=> !irq_req)
    else $error("request raised with global enable off");

  a_ack_clear: assert property (@(posedge clk) disable iff (srst)
    vector_ack && irq_vector == `IMFU_VEC_T1_CAP && !t1_capture_event
      |=> !st.timer_irq_flags[3])
    else $error("vectoring did not clear capture flag");

  a_ack_drop: assert property (@(posedge clk) disable iff (srst)
    vector_ack |=> !irq_req && !st.gie)
    else $error("request or global enable kept after vector");

  a_rdata_idle: assert property (@(posedge clk) disable iff (srst)
    !rd |=> rdata == 8'h00)
    else $error("read data not zero outside a read");

endmodule

/* File: testbench/imfu_core_model.sv */
// core side model: request pin pads and vector acknowledge
// assumes irq_req is registered on clk and held until acknowledged
`timescale 1ns/1ps

module imfu_core_model (
  // clock
  input wire logic clk,
  // bench control
  input wire logic [1:0] pin_cmd,
  input wire logic [1:0] ack_wait,
  // unit side
  input wire logic irq_req,
  output logic [1:0] ext_pin,
  output logic vector_ack
);
  logic [1:0] cnt;

  initial begin
    ext_pin = 2'h3;
    vector_ack = 1'b0;
    cnt = 2'h0;
  end

  // ----------------------------------------------------------------
  // pads follow the bench; ack after ack_wait + 1 cycles of request
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    ext_pin <= pin_cmd;
    vector_ack <= 1'b0;
    if (!irq_req || vector_ack) begin
      cnt <= 2'h0;
    end else if (cnt != ack_wait) begin
      cnt <= cnt + 2'h1;
    end else begin
      vector_ack <= 1'b1;
    end
  end
endmodule

/* File: testbench/testbench.sv */
// self-checking bench of the interrupt mask and flag unit
// assumes imfu_top and imfu_core_model are compiled first
`timescale 1ns/1ps

module testbench;
  logic clk, srst, wr, rd, irq_req, vector_ack;
  logic [5:0] addr, ev;
  logic [7:0] wdata, rdata, exp;
  logic [1:0] ext_pin, pin_cmd, ack_wait;
  logic [2:0] irq_vector;
  logic [7:0] tbits [4] = '{8'h40, 8'h20, 8'h08, 8'h02};
  int n_mismatch, checked;

  imfu_top dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .ext_pin(ext_pin),
    .t1_overflow(ev[0]), .t1_pwm_turn_zero(ev[1]),
    .t1_cmp_a_match(ev[2]), .t1_cmp_b_match(ev[3]),
    .t1_capture_event(ev[4]), .t0_overflow(ev[5]),
    .vector_ack(vector_ack), .irq_req(irq_req),
    .irq_vector(irq_vector));

  imfu_core_model core (.clk(clk), .pin_cmd(pin_cmd),
    .ack_wait(ack_wait), .irq_req(irq_req), .ext_pin(ext_pin),
    .vector_ack(vector_ack));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] e);
    checked++;
    if (seen !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, e);
    end
  endtask

  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask

  task automatic pulse(input logic [5:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 6'h00;
    @(posedge clk);
  endtask

  task automatic pins(input logic [1:0] p);
    @(posedge clk);
    pin_cmd <= p;
    repeat (3) @(posedge clk);
  endtask

  task automatic wait_vec(input logic [2:0] e);
    int i;
    i = 0;
    while (vector_ack !== 1'b1 && i < 20) begin
      @(posedge clk);
      #1 i++;
    end
    if (vector_ack !== 1'b1) begin
      n_mismatch++;
      give_verdict();
    end else begin
      chk({5'h0, irq_vector}, {5'h0, e});
      @(posedge clk);
      #1 chk({7'h0, irq_req}, 8'h00);
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    n_mismatch = 0;
    checked = 0;
    srst = 1'b1;
    {wr, rd, addr, wdata, ev, ack_wait} = '0;
    pin_cmd = 2'h3;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    for (int k = 0; k < 4; k++) rd_chk(6'h38 + 6'(k), 8'h00);
    rd_chk(6'h00, 8'h00);
    wr_reg(6'h39, 8'hff);
    rd_chk(6'h39, 8'hea);
    wr_reg(6'h3b, 8'hff);
    rd_chk(6'h3b, 8'hc0);
    wr_reg(6'h3b, 8'h00);
    wr_reg(6'h39, 8'h00);
    $display("registers done");
    pulse(6'h01);
    rd_chk(6'h38, 8'h80);
    wr_reg(6'h38, 8'h80);
    rd_chk(6'h38, 8'h00);
    pulse(6'h02);
    exp = 8'h80;
    rd_chk(6'h38, exp);
    for (int k = 0; k < 4; k++) begin
      pulse(6'h04 << k);
      exp = exp | tbits[k];
      rd_chk(6'h38, exp);
    end
    wr_reg(6'h38, 8'h02);
    rd_chk(6'h38, 8'he8);
    wr_reg(6'h38, 8'h00);
    rd_chk(6'h38, 8'he8);
    pulse(6'h20);
    wr_reg(6'h39, 8'hea);
    #1 chk({7'h0, irq_req}, 8'h00);
    for (int v = 3; v < 8; v++) begin
      ack_wait <= 2'(v);
      wr_reg(6'h3f, 8'h80);
      wait_vec(3'(v));
    end
    rd_chk(6'h38, 8'h00);
    $display("timer sources done");
    wr_reg(6'h39, 8'h00);
    wr_reg(6'h3b, 8'h00);
    wr_reg(6'h35, 8'h0b);
    wr_reg(6'h3b, 8'hc0);
    pins(2'h0);
    rd_chk(6'h3a, 8'h80);
    pins(2'h1);
    rd_chk(6'h3a, 8'hc0);
    wr_reg(6'h3f, 8'h80);
    wait_vec(3'h1);
    wr_reg(6'h3f, 8'h80);
    wait_vec(3'h2);
    rd_chk(6'h3a, 8'h00);
    wr_reg(6'h3b, 8'h00);
    wr_reg(6'h35, 8'h05);
    pins(2'h2);
    pins(2'h1);
    rd_chk(6'h3a, 8'h00);
    wr_reg(6'h35, 8'h0e);
    pins(2'h2);
    rd_chk(6'h3a, 8'hc0);
    wr_reg(6'h3a, 8'hc0);
    rd_chk(6'h3a, 8'h00);
    pins(2'h3);
    wr_reg(6'h35, 8'h00);
    wr_reg(6'h3b, 8'h40);
    wr_reg(6'h3f, 8'h80);
    #1 chk({7'h0, irq_req}, 8'h00);
    pins(2'h2);
    wait_vec(3'h1);
    wr_reg(6'h3f, 8'h80);
    wait_vec(3'h1);
    wr_reg(6'h3b, 8'h00);
    wr_reg(6'h3f, 8'h80);
    repeat (3) @(posedge clk);
    #1 chk({7'h0, irq_req}, 8'h00);
    rd_chk(6'h3a, 8'h00);
    $display("pin sources done");
    give_verdict();
  end
endmodule
